// [atc_pkg.sv]
package atc_pkg;

    // Task-file offsets.
    localparam logic [2:0] OFS_DATA = 3'h0;
    localparam logic [2:0] OFS_FEATURE = 3'h1;
    localparam logic [2:0] OFS_SEC_COUNT = 3'h2;
    localparam logic [2:0] OFS_SEC_NUMBER = 3'h3;
    localparam logic [2:0] OFS_CYL_LOW = 3'h4;
    localparam logic [2:0] OFS_CYL_HIGH = 3'h5;
    localparam logic [2:0] OFS_DRIVE_HEAD = 3'h6;
    localparam logic [2:0] OFS_COMMAND = 3'h7;

    // Drive/head field layout.
    localparam int DH_LBA_BIT = 6;
    localparam int DH_DRIVE_BIT = 4;
    localparam int DH_HEAD_MSB = 3;

    // Status and error bits.
    localparam int ST_BSY = 7;
    localparam int ST_DRDY = 6;
    localparam int ST_DSC = 4;
    localparam int ST_DRQ = 3;
    localparam int ST_ERR = 0;
    localparam int ER_ABRT = 2;

    // Command codes.
    localparam logic [7:0] CMD_POWER_QUERY_A = 8'he5;
    localparam logic [7:0] CMD_POWER_QUERY_B = 8'h98;
    localparam logic [7:0] CMD_ERASE = 8'hc0;
    localparam logic [7:0] CMD_DIAGNOSE = 8'h90;
    localparam logic [7:0] CMD_FLUSH = 8'he7;
    localparam logic [7:0] CMD_FORMAT = 8'h50;
    localparam logic [7:0] CMD_IDENTIFY = 8'hec;

    // Replies and diagnostic codes.
    localparam logic [7:0] POWER_ACTIVE_REPLY = 8'h00;
    localparam logic [7:0] DIAG_NO_ERROR = 8'h01;
    localparam logic [7:0] DIAG_SLAVE_FAIL = 8'h80;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // Register values after reset.
    localparam logic [7:0] RST_STATUS = 8'h50;
    localparam logic [7:0] RST_DRIVE_HEAD = 8'ha0;
    localparam logic [7:0] RST_SECTOR = 8'h01;

    // One sector buffer of 16-bit words.
    localparam int BUF_WORDS = 256;
    localparam logic [7:0] BUF_LAST = 8'hff;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_EXEC = 6'b000010,
        ST_WRITE_IN = 6'b000100,
        ST_READ_OUT = 6'b001000,
        ST_FLUSH = 6'b010000,
        ST_DONE = 6'b100000
    } atc_state_e;

endpackage : atc_pkg

// [atc_identify_rom.sv]
`timescale 1ns/1ps

// Identify parameter words; every word not listed is reserved and reads zero.
module atc_identify_rom #(
    parameter logic [15:0] DEF_CYLINDERS = 16'h0100,
    parameter logic [15:0] DEF_HEADS = 16'h0010,
    parameter logic [15:0] DEF_SECTORS = 16'h0020
) (
    input wire logic [7:0] word_index,
    output logic [15:0] word_data
);

    always_comb begin
        case (word_index)
            8'h00: word_data = 16'h044a;
            8'h01: word_data = DEF_CYLINDERS;
            8'h03: word_data = DEF_HEADS;
            8'h06: word_data = DEF_SECTORS;
            8'h14: word_data = 16'h0002;
            8'h15: word_data = 16'h0200;
            8'h16: word_data = 16'h0004;
            8'h2f: word_data = 16'h0001;
            8'h31: word_data = 16'h0b00;
            8'h33: word_data = 16'h0200;
            8'h35: word_data = 16'h0003;
            8'h36: word_data = DEF_CYLINDERS;
            8'h37: word_data = DEF_HEADS;
            8'h38: word_data = DEF_SECTORS;
            8'h3b: word_data = 16'h0101;
            8'h40: word_data = 16'h0003;
            8'h41: word_data = 16'h0078;
            8'h42: word_data = 16'h0078;
            8'h43: word_data = 16'h0078;
            8'h44: word_data = 16'h0078;
            8'h50: word_data = 16'h007e;
            8'h51: word_data = 16'h0019;
            default: word_data = 16'h0000;
        endcase
    end

endmodule : atc_identify_rom

// [atc_command_handler.sv]
`timescale 1ns/1ps

module atc_command_handler #(
    parameter logic [15:0] DEF_CYLINDERS = 16'h0100,
    parameter logic [15:0] DEF_HEADS = 16'h0010,
    parameter logic [15:0] DEF_SECTORS = 16'h0020
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [2:0] tf_addr,
    input wire logic tf_wr,
    input wire logic [7:0] tf_wdata,
    input wire logic tf_rd,
    output logic [7:0] tf_rdata,
    input wire logic data_wr,
    input wire logic [15:0] data_wdata,
    input wire logic data_rd,
    output logic [15:0] data_rdata,
    output logic intrq,
    input wire logic drive_id,
    input wire logic [7:0] self_test_code,
    input wire logic slave_present,
    input wire logic slave_pass,
    output logic flush_req,
    input wire logic flush_done,
    output logic [27:0] target_lba,
    output logic target_lba_mode
);

    atc_pkg::atc_state_e state_reg, state_next;
    logic [7:0] feature_parameter_reg, feature_parameter_next;
    logic [7:0] sector_count_reg, sector_count_next;
    logic [7:0] sector_number_lba_low_reg, sector_number_lba_low_next;
    logic [7:0] cylinder_low_lba_mid_reg, cylinder_low_lba_mid_next;
    logic [7:0] cylinder_high_lba_upper_reg, cylinder_high_lba_upper_next;
    logic [7:0] drive_head_select_reg, drive_head_select_next;
    logic [7:0] command_code_reg, command_code_next;
    logic [7:0] status_reg, status_next;
    logic [7:0] error_reg, error_next;
    logic [7:0] word_cnt_reg, word_cnt_next;
    logic [7:0] tf_rdata_reg, tf_rdata_next;
    logic [15:0] data_rdata_reg, data_rdata_next;
    logic intrq_reg, intrq_next;
    logic flush_req_reg, flush_req_next;
    logic [27:0] target_lba_reg, target_lba_next;
    logic target_lba_mode_reg, target_lba_mode_next;
    logic [15:0] rom_word;
    logic drive_match;

    // Commands that take the full address set, head field included.
    function automatic logic uses_full_address(input logic [7:0] cmd);
        return (cmd == atc_pkg::CMD_ERASE) || (cmd == atc_pkg::CMD_FORMAT);
    endfunction : uses_full_address

    function automatic logic is_power_query(input logic [7:0] cmd);
        return (cmd == atc_pkg::CMD_POWER_QUERY_A) || (cmd == atc_pkg::CMD_POWER_QUERY_B);
    endfunction : is_power_query

    atc_identify_rom #(
        .DEF_CYLINDERS(DEF_CYLINDERS),
        .DEF_HEADS(DEF_HEADS),
        .DEF_SECTORS(DEF_SECTORS)
    ) u_rom (
        .word_index(word_cnt_reg),
        .word_data(rom_word)
    );

    assign drive_match = drive_head_select_reg[atc_pkg::DH_DRIVE_BIT] == drive_id;

    always_comb begin
        state_next = state_reg;
        feature_parameter_next = feature_parameter_reg;
        sector_count_next = sector_count_reg;
        sector_number_lba_low_next = sector_number_lba_low_reg;
        cylinder_low_lba_mid_next = cylinder_low_lba_mid_reg;
        cylinder_high_lba_upper_next = cylinder_high_lba_upper_reg;
        drive_head_select_next = drive_head_select_reg;
        command_code_next = command_code_reg;
        status_next = status_reg;
        error_next = error_reg;
        word_cnt_next = word_cnt_reg;
        tf_rdata_next = tf_rdata_reg;
        data_rdata_next = data_rdata_reg;
        intrq_next = intrq_reg;
        flush_req_next = flush_req_reg;
        target_lba_next = target_lba_reg;
        target_lba_mode_next = target_lba_mode_reg;

        // Reading status acknowledges the interrupt.
        if (tf_rd) begin
            case (tf_addr)
                atc_pkg::OFS_FEATURE: tf_rdata_next = error_reg;
                atc_pkg::OFS_SEC_COUNT: tf_rdata_next = sector_count_reg;
                atc_pkg::OFS_SEC_NUMBER: tf_rdata_next = sector_number_lba_low_reg;
                atc_pkg::OFS_CYL_LOW: tf_rdata_next = cylinder_low_lba_mid_reg;
                atc_pkg::OFS_CYL_HIGH: tf_rdata_next = cylinder_high_lba_upper_reg;
                atc_pkg::OFS_DRIVE_HEAD: tf_rdata_next = drive_head_select_reg;
                atc_pkg::OFS_COMMAND: begin
                    tf_rdata_next = status_reg;
                    intrq_next = 1'b0;
                end
                default: tf_rdata_next = atc_pkg::BYTE_ZERO;
            endcase
        end

        // Task-file writes are ignored while busy so a running command keeps its parameters.
        if (tf_wr && !status_reg[atc_pkg::ST_BSY]) begin
            case (tf_addr)
                atc_pkg::OFS_FEATURE: feature_parameter_next = tf_wdata;
                atc_pkg::OFS_SEC_COUNT: sector_count_next = tf_wdata;
                atc_pkg::OFS_SEC_NUMBER: sector_number_lba_low_next = tf_wdata;
                atc_pkg::OFS_CYL_LOW: cylinder_low_lba_mid_next = tf_wdata;
                atc_pkg::OFS_CYL_HIGH: cylinder_high_lba_upper_next = tf_wdata;
                atc_pkg::OFS_DRIVE_HEAD: drive_head_select_next = tf_wdata;
                atc_pkg::OFS_COMMAND: begin
                    command_code_next = tf_wdata;
                    status_next = '0;
                    status_next[atc_pkg::ST_BSY] = 1'b1;
                    error_next = atc_pkg::BYTE_ZERO;
                    intrq_next = 1'b0;
                    state_next = atc_pkg::ST_EXEC;
                end
                default: ;
            endcase
        end

        case (state_reg)
            atc_pkg::ST_IDLE: ;
            atc_pkg::ST_EXEC: begin
                word_cnt_next = '0;
                state_next = atc_pkg::ST_DONE;
                if (uses_full_address(command_code_reg)) begin
                    // Only commands that define these registers take them as an address.
                    target_lba_next = {drive_head_select_reg[atc_pkg::DH_HEAD_MSB:0],
                                       cylinder_high_lba_upper_reg,
                                       cylinder_low_lba_mid_reg,
                                       sector_number_lba_low_reg};
                    target_lba_mode_next = drive_head_select_reg[atc_pkg::DH_LBA_BIT];
                end
                if (command_code_reg == atc_pkg::CMD_DIAGNOSE) begin
                    // Drive select plays no part; a slave fault marks the master's report.
                    error_next = self_test_code;
                    if (!drive_id && slave_present && !slave_pass) begin
                        error_next = atc_pkg::DIAG_SLAVE_FAIL | self_test_code;
                    end
                    // A slave fault is part of the master's report, so it raises ERR as well.
                    if (error_next != atc_pkg::DIAG_NO_ERROR) begin
                        status_next[atc_pkg::ST_ERR] = 1'b1;
                    end
                end else if (!drive_match) begin
                    // The other drive owns this command; stay silent.
                    status_next = '0;
                    state_next = atc_pkg::ST_IDLE;
                end else if (is_power_query(command_code_reg)) begin
                    sector_count_next = atc_pkg::POWER_ACTIVE_REPLY;
                end else if (command_code_reg == atc_pkg::CMD_FLUSH) begin
                    flush_req_next = 1'b1;
                    state_next = atc_pkg::ST_FLUSH;
                end else if (command_code_reg == atc_pkg::CMD_FORMAT) begin
                    status_next[atc_pkg::ST_BSY] = 1'b0;
                    status_next[atc_pkg::ST_DRQ] = 1'b1;
                    state_next = atc_pkg::ST_WRITE_IN;
                end else if (command_code_reg == atc_pkg::CMD_IDENTIFY) begin
                    status_next[atc_pkg::ST_BSY] = 1'b0;
                    status_next[atc_pkg::ST_DRQ] = 1'b1;
                    data_rdata_next = rom_word;
                    intrq_next = 1'b1;
                    state_next = atc_pkg::ST_READ_OUT;
                end else begin
                    // Erase and every command this block does not carry are aborted.
                    status_next[atc_pkg::ST_ERR] = 1'b1;
                    error_next[atc_pkg::ER_ABRT] = 1'b1;
                end
            end
            atc_pkg::ST_WRITE_IN: begin
                if (data_wr) begin
                    // Words are counted and dropped; the format data is never used.
                    word_cnt_next = word_cnt_reg + 8'h01;
                    if (word_cnt_reg == atc_pkg::BUF_LAST) begin
                        status_next[atc_pkg::ST_DRQ] = 1'b0;
                        status_next[atc_pkg::ST_BSY] = 1'b1;
                        state_next = atc_pkg::ST_DONE;
                    end
                end
            end
            atc_pkg::ST_READ_OUT: begin
                if (data_rd) begin
                    word_cnt_next = word_cnt_reg + 8'h01;
                    if (word_cnt_reg == atc_pkg::BUF_LAST) begin
                        status_next[atc_pkg::ST_DRQ] = 1'b0;
                        status_next[atc_pkg::ST_DRDY] = 1'b1;
                        status_next[atc_pkg::ST_DSC] = 1'b1;
                        state_next = atc_pkg::ST_IDLE;
                    end
                end
            end
            atc_pkg::ST_FLUSH: begin
                if (flush_done) begin
                    flush_req_next = 1'b0;
                    state_next = atc_pkg::ST_DONE;
                end
            end
            atc_pkg::ST_DONE: begin
                // Completion, good or bad, ends the same way; the set beats a status read.
                status_next[atc_pkg::ST_BSY] = 1'b0;
                status_next[atc_pkg::ST_DRDY] = 1'b1;
                status_next[atc_pkg::ST_DSC] = 1'b1;
                intrq_next = 1'b1;
                state_next = atc_pkg::ST_IDLE;
            end
            default: state_next = atc_pkg::ST_IDLE;
        endcase

        // Present the next identify word once the counter has moved on.
        if (state_reg == atc_pkg::ST_READ_OUT) begin
            data_rdata_next = rom_word;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= atc_pkg::ST_IDLE;
            feature_parameter_reg <= atc_pkg::BYTE_ZERO;
            sector_count_reg <= atc_pkg::RST_SECTOR;
            sector_number_lba_low_reg <= atc_pkg::RST_SECTOR;
            cylinder_low_lba_mid_reg <= atc_pkg::BYTE_ZERO;
            cylinder_high_lba_upper_reg <= atc_pkg::BYTE_ZERO;
            drive_head_select_reg <= atc_pkg::RST_DRIVE_HEAD;
            command_code_reg <= atc_pkg::BYTE_ZERO;
            status_reg <= atc_pkg::RST_STATUS;
            error_reg <= atc_pkg::DIAG_NO_ERROR;
            word_cnt_reg <= atc_pkg::BYTE_ZERO;
            tf_rdata_reg <= atc_pkg::BYTE_ZERO;
            data_rdata_reg <= '0;
            intrq_reg <= 1'b0;
            flush_req_reg <= 1'b0;
            target_lba_reg <= '0;
            target_lba_mode_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            feature_parameter_reg <= feature_parameter_next;
            sector_count_reg <= sector_count_next;
            sector_number_lba_low_reg <= sector_number_lba_low_next;
            cylinder_low_lba_mid_reg <= cylinder_low_lba_mid_next;
            cylinder_high_lba_upper_reg <= cylinder_high_lba_upper_next;
            drive_head_select_reg <= drive_head_select_next;
            command_code_reg <= command_code_next;
            status_reg <= status_next;
            error_reg <= error_next;
            word_cnt_reg <= word_cnt_next;
            tf_rdata_reg <= tf_rdata_next;
            data_rdata_reg <= data_rdata_next;
            intrq_reg <= intrq_next;
            flush_req_reg <= flush_req_next;
            target_lba_reg <= target_lba_next;
            target_lba_mode_reg <= target_lba_mode_next;
        end
    end

    assign tf_rdata = tf_rdata_reg;
    assign data_rdata = data_rdata_reg;
    assign intrq = intrq_reg;
    assign flush_req = flush_req_reg;
    assign target_lba = target_lba_reg;
    assign target_lba_mode = target_lba_mode_reg;

endmodule : atc_command_handler

// [atc_command_handler_asserts.sv]
`timescale 1ns/1ps

module atc_command_handler_asserts (
    input wire logic clock,
    input wire logic rst,
    input wire logic [2:0] tf_addr,
    input wire logic tf_wr,
    input wire logic [7:0] tf_wdata,
    input wire logic tf_rd,
    input wire logic [7:0] tf_rdata,
    input wire logic intrq,
    input wire logic flush_req,
    input wire logic flush_done,
    input wire logic [27:0] target_lba,
    input wire logic target_lba_mode
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    logic cmd_wr;
    logic fl_cmd;
    logic lba_cmd;
    assign cmd_wr = tf_wr && tf_addr == atc_pkg::OFS_COMMAND;
    assign fl_cmd = cmd_wr && tf_wdata == atc_pkg::CMD_FLUSH;
    assign lba_cmd = cmd_wr && (tf_wdata == atc_pkg::CMD_ERASE || tf_wdata == atc_pkg::CMD_FORMAT);

    a_flush_hold: assert property (flush_req && !flush_done |=> flush_req)
        else $error("flush request dropped early");
    a_flush_drop: assert property (flush_req && flush_done |-> ##[1:2] !flush_req)
        else $error("flush request kept after done");
    a_flush_irq: assert property (flush_req && flush_done |-> ##[1:6] intrq)
        else $error("no interrupt after flush");
    a_flush_cause: assert property ($rose(flush_req) |->
        $past(fl_cmd) || $past(fl_cmd, 2) || $past(fl_cmd, 3))
        else $error("flush request without command");
    a_lba_cause: assert property (!$stable({target_lba, target_lba_mode}) |->
        $past(lba_cmd) || $past(lba_cmd, 2) || $past(lba_cmd, 3))
        else $error("target address changed without command");
    a_irq_hold: assert property (intrq && !(tf_rd && tf_addr == 3'h7) && !cmd_wr |=> intrq)
        else $error("interrupt lost without status read");
    a_rdata_cause: assert property (!$stable(tf_rdata) |-> $past(tf_rd))
        else $error("read data changed without read");
    a_unmapped_zero: assert property (tf_rd && tf_addr == 3'h0 |=> tf_rdata == 8'h00)
        else $error("unmapped read not zero");
endmodule : atc_command_handler_asserts

// [atc_host_model.sv]
`timescale 1ns/1ps

module atc_host_model (
    input wire logic clock,
    output logic [2:0] tf_addr,
    output logic tf_wr,
    output logic [7:0] tf_wdata,
    output logic tf_rd,
    input wire logic [7:0] tf_rdata,
    output logic data_wr,
    output logic [15:0] data_wdata,
    output logic data_rd,
    input wire logic [15:0] data_rdata
);
    initial begin
        tf_addr = 3'h0;
        tf_wr = 1'b0;
        tf_wdata = 8'h00;
        tf_rd = 1'b0;
        data_wr = 1'b0;
        data_wdata = 16'h0000;
        data_rd = 1'b0;
    end

    // Data lines show the inverse of the last value once a strobe ends.
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clock);
        tf_addr <= a;
        tf_wdata <= d;
        tf_wr <= 1'b1;
        @(posedge clock);
        tf_wr <= 1'b0;
        tf_wdata <= ~d;
    endtask : wr_reg

    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clock);
        tf_addr <= a;
        tf_rd <= 1'b1;
        @(posedge clock);
        tf_rd <= 1'b0;
        #1;
        d = tf_rdata;
    endtask : rd_reg

    task automatic set_addr(input logic lba, input logic drv, input logic [27:0] a);
        wr_reg(atc_pkg::OFS_DRIVE_HEAD, {1'b1, lba, 1'b1, drv, a[27:24]});
        wr_reg(atc_pkg::OFS_CYL_HIGH, a[23:16]);
        wr_reg(atc_pkg::OFS_CYL_LOW, a[15:8]);
        wr_reg(atc_pkg::OFS_SEC_NUMBER, a[7:0]);
    endtask : set_addr

    task automatic wr_word(input logic [15:0] v);
        @(posedge clock);
        data_wdata <= v;
        data_wr <= 1'b1;
        @(posedge clock);
        data_wr <= 1'b0;
        data_wdata <= ~v;
    endtask : wr_word

    task automatic rd_word(output logic [15:0] v);
        #1;
        v = data_rdata;
        @(posedge clock);
        data_rd <= 1'b1;
        @(posedge clock);
        data_rd <= 1'b0;
        repeat (2) @(posedge clock);
    endtask : rd_word
endmodule : atc_host_model

// [tb_atc_command_handler.sv]
`timescale 1ns/1ps
`define CHECK(nm, e, g) begin \
    n_tests++; \
    if ((g) !== (e)) begin \
        miscompares++; \
        $display("[ERR] %s expected %h seen %h", nm, e, g); \
    end \
end

module tb_atc_command_handler;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [2:0] tf_addr;
    logic tf_wr, tf_rd, data_wr, data_rd, intrq, flush_req, target_lba_mode;
    logic [7:0] tf_wdata, tf_rdata, rb;
    logic [15:0] data_wdata, data_rdata, w;
    logic [16:0] ew;
    logic [27:0] target_lba;
    logic drive_id = 1'b0;
    logic [7:0] self_test_code = 8'h01;
    logic slave_present = 1'b0;
    logic slave_pass = 1'b0;
    logic flush_done = 1'b0;
    int miscompares = 0;
    int n_tests = 0;
    logic [7:0] rst_vals [8] = '{8'h00, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00, 8'ha0, 8'h50};
    // Fields: drive_id, slave_present, slave_pass, drive bit, own code, expected error.
    logic [19:0] diag [7] = '{20'h70101, 20'h40181, 20'h10202, 20'h60303, 20'h50484,
        20'hc0505, 20'h80101};

    always #50 clock = ~clock;

    atc_command_handler #(.DEF_CYLINDERS(16'h0123), .DEF_HEADS(16'h0009),
        .DEF_SECTORS(16'h0031)) dut_u (.clock(clock), .rst(rst), .tf_addr(tf_addr),
        .tf_wr(tf_wr), .tf_wdata(tf_wdata), .tf_rd(tf_rd), .tf_rdata(tf_rdata),
        .data_wr(data_wr), .data_wdata(data_wdata), .data_rd(data_rd),
        .data_rdata(data_rdata), .intrq(intrq), .drive_id(drive_id),
        .self_test_code(self_test_code), .slave_present(slave_present),
        .slave_pass(slave_pass), .flush_req(flush_req), .flush_done(flush_done),
        .target_lba(target_lba), .target_lba_mode(target_lba_mode));

    atc_host_model host_u (.clock(clock), .tf_addr(tf_addr), .tf_wr(tf_wr),
        .tf_wdata(tf_wdata), .tf_rd(tf_rd), .tf_rdata(tf_rdata), .data_wr(data_wr),
        .data_wdata(data_wdata), .data_rd(data_rd), .data_rdata(data_rdata));

    task automatic conclude();
        $display("Checks %0d, mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    task automatic wait_for(input logic sel);
        int n;
        for (n = 0; n < 400; n++) begin
            @(posedge clock);
            #1;
            if ((sel ? flush_req : intrq) === 1'b1) break;
        end
        if (n == 400) begin
            miscompares++;
            $display("[ERR] wait timed out");
            conclude();
        end
    endtask : wait_for

    task automatic cmd(input logic [7:0] c);
        host_u.wr_reg(atc_pkg::OFS_COMMAND, c);
    endtask : cmd

    task automatic done(input logic [7:0] st);
        wait_for(1'b0);
        host_u.rd_reg(atc_pkg::OFS_COMMAND, rb);
        `CHECK("status", st, rb)
    endtask : done

    // Bit 16 marks a word whose value is known here.
    function automatic logic [16:0] id_word(input int i);
        if (i == 2 || i == 4 || i == 5 || i == 48 || i == 50 || i == 52 || i == 62 || i == 88
            || (i >= 69 && i <= 79) || (i >= 92 && i <= 127) || i >= 161) return 17'h10000;
        case (i)
            0: return 17'h1044a;
            1: return 17'h10123;
            3: return 17'h10009;
            6: return 17'h10031;
            47: return 17'h10001;
            53: return 17'h10003;
            default: return 17'h00000;
        endcase
    endfunction : id_word

    initial begin
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        for (int a = 0; a < 8; a++) begin
            host_u.rd_reg(a[2:0], rb);
            `CHECK("reset value", rst_vals[a], rb)
        end
        for (int k = 0; k < 2; k++) begin
            host_u.wr_reg(atc_pkg::OFS_SEC_COUNT, 8'h37);
            cmd(k ? atc_pkg::CMD_POWER_QUERY_B : atc_pkg::CMD_POWER_QUERY_A);
            done(8'h50);
            host_u.rd_reg(atc_pkg::OFS_SEC_COUNT, rb);
            `CHECK("power reply", 8'h00, rb)
        end
        host_u.set_addr(1'b1, 1'b0, 28'h5123456);
        cmd(atc_pkg::CMD_ERASE);
        done(8'h51);
        host_u.rd_reg(atc_pkg::OFS_FEATURE, rb);
        `CHECK("erase error", 8'h04, rb)
        `CHECK("erase lba", 28'h5123456, target_lba)
        `CHECK("erase mode", 1'b1, target_lba_mode)
        host_u.set_addr(1'b0, 1'b0, 28'h2001122);
        cmd(atc_pkg::CMD_ERASE);
        done(8'h51);
        `CHECK("chs mode", 1'b0, target_lba_mode)
        for (int k = 0; k < 7; k++) begin
            @(posedge clock);
            {drive_id, slave_present, slave_pass} <= diag[k][19:17];
            self_test_code <= diag[k][15:8];
            host_u.wr_reg(atc_pkg::OFS_DRIVE_HEAD, {3'b101, diag[k][16], 4'h0});
            cmd(atc_pkg::CMD_DIAGNOSE);
            done(diag[k][7:0] == 8'h01 ? 8'h50 : 8'h51);
            host_u.rd_reg(atc_pkg::OFS_FEATURE, rb);
            `CHECK("diag code", diag[k][7:0], rb)
        end
        @(posedge clock);
        drive_id <= 1'b0;
        host_u.wr_reg(atc_pkg::OFS_DRIVE_HEAD, 8'hb0);
        cmd(atc_pkg::CMD_FLUSH);
        repeat (10) @(posedge clock);
        #1;
        `CHECK("other drive irq", 1'b0, intrq)
        `CHECK("other drive flush", 1'b0, flush_req)
        host_u.rd_reg(atc_pkg::OFS_COMMAND, rb);
        `CHECK("other drive status", 8'h00, rb)
        host_u.wr_reg(atc_pkg::OFS_DRIVE_HEAD, 8'ha0);
        cmd(atc_pkg::CMD_FLUSH);
        wait_for(1'b1);
        repeat (20) @(posedge clock);
        #1;
        `CHECK("flush early irq", 1'b0, intrq)
        @(posedge clock);
        flush_done <= 1'b1;
        @(posedge clock);
        flush_done <= 1'b0;
        done(8'h50);
        host_u.set_addr(1'b1, 1'b0, 28'h0a1b2c3);
        cmd(atc_pkg::CMD_FORMAT);
        rb = 8'h00;
        for (int n = 0; n < 20 && rb !== 8'h08; n++) host_u.rd_reg(atc_pkg::OFS_COMMAND, rb);
        `CHECK("format drq", 8'h08, rb)
        for (int k = 0; k < atc_pkg::BUF_WORDS; k++) host_u.wr_word(16'(k * 3));
        done(8'h50);
        `CHECK("format lba", 28'h0a1b2c3, target_lba)
        cmd(atc_pkg::CMD_IDENTIFY);
        done(8'h08);
        for (int k = 0; k < atc_pkg::BUF_WORDS; k++) begin
            host_u.rd_word(w);
            ew = id_word(k);
            if (ew[16]) `CHECK("identify word", ew[15:0], w)
        end
        host_u.rd_reg(atc_pkg::OFS_COMMAND, rb);
        `CHECK("identify end", 8'h50, rb)
        conclude();
    end
endmodule : tb_atc_command_handler

bind atc_command_handler atc_command_handler_asserts chk_u (.clock(clock), .rst(rst),
    .tf_addr(tf_addr), .tf_wr(tf_wr), .tf_wdata(tf_wdata), .tf_rd(tf_rd),
    .tf_rdata(tf_rdata), .intrq(intrq), .flush_req(flush_req), .flush_done(flush_done),
    .target_lba(target_lba), .target_lba_mode(target_lba_mode));
